// ### include/np_irq_consts.svh
// Offsets, field positions, reset values and widths for the next-page word and interrupt mask
// Assumes 16-bit registers on a 32-bit Avalon-MM word bus, one register per aligned word
`ifndef NP_IRQ_CONSTS_SVH
`define NP_IRQ_CONSTS_SVH

`define AV_ADDR_W         8
`define REG_IDX_W         6
`define REG_IDX_NP_TX     6'h07
`define REG_IDX_MASK      6'h10
`define REG_IDX_STATUS    6'h11
`define REG_IDX_CONFIG    6'h1C

`define NP_BIT_NEXT_PAGE  15
`define NP_BIT_ACK        14
`define NP_BIT_MSG_PAGE   13
`define NP_BIT_ACK2       12
`define NP_BIT_TOGGLE     11
`define NP_CODE_W         11
`define NP_CODE_RESET     11'h001
`define NP_MSG_PAGE_RESET 1'h1

`define IRQ_NUM_EVENTS    4
`define IRQ_FIELD_LSB     12
`define IRQ_MASK_RESET    4'h4
`define CFG_BIT_LEGACY    0

`endif

// ### include/np_irq_pkg.sv
// Types shared by the next-page and interrupt mask logic
// Assumes np_irq_consts.svh supplies all numbers
package np_irq_pkg;

   // Events from the receive side, all on clk_in; order matches mask bits 15 down to 12
   typedef struct packed {
      logic cim_unstable;   // Pulse: carrier integrity monitor saw an unstable link
      logic link_up;        // Level: current link status
      logic lock_ok;        // Level: descrambler locked
      logic premature_end;  // Pulse: two idles inside a frame without delimiter
   } irq_event_t;

   // Next-page transmit word as handed to the negotiation logic
   typedef struct packed {
      logic        next_page;
      logic        ack;
      logic        msg_page;
      logic        ack2;
      logic        toggle;
      logic [10:0] code;
   } np_word_t;

endpackage : np_irq_pkg

// ### rtl/irq_status_bank.sv
// Sticky interrupt status bits with read clear and masked pending output
// Assumes set and clear vectors are on clk_in
`timescale 1ns/1ps
module irq_status_bank #(
   parameter int N = 4
) (
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic [N-1:0] set_in,
   input  wire logic [N-1:0] clr_in,
   input  wire logic [N-1:0] mask_in,
   output logic      [N-1:0] status_out,
   output logic              pending_out
);

   logic [N-1:0] status_r;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         // Set wins over a read clear in the same cycle
         always_ff @(posedge clk_in) begin
            if (srst_in) begin
               status_r[i] <= 1'b0;
            end else begin
               status_r[i] <= set_in[i] | (status_r[i] & ~clr_in[i]);
            end
         end
      end
   endgenerate

   assign status_out  = status_r;
   assign pending_out = |(status_r & mask_in);

endmodule : irq_status_bank

// ### rtl/np_irq_regs.sv
// Register file for the next-page transmit word, interrupt mask, status and legacy mode
// Assumes an Avalon-MM master on clk_in and event sources on the same clock
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "np_irq_consts.svh"
module np_irq_regs (
   input  wire logic                    clk_in,
   input  wire logic                    srst_in,
   input  wire logic [`AV_ADDR_W-1:0]   address_in,
   input  wire logic                    read_in,
   input  wire logic                    write_in,
   input  wire logic [31:0]             writedata_in,
   input  wire logic [3:0]              byteenable_in,
   output logic      [31:0]             readdata_out,
   output logic                         waitrequest_out,
   input  wire np_irq_pkg::irq_event_t  events_in,
   input  wire logic                    lp_consistent_in,
   input  wire logic                    page_sent_in,
   output np_irq_pkg::np_word_t         np_tx_word_out,
   output logic                         legacy_mode_out,
   output logic                         irq_n_out
);

   localparam int NE = `IRQ_NUM_EVENTS;

   logic                    waitrequest_r;
   logic [31:0]             readdata_r;
   logic [31:0]             rd_word;
   logic                    req;
   logic                    launch;
   logic                    done;
   logic [`REG_IDX_W-1:0]   idx;
   logic                    wr_lo;
   logic                    wr_hi;
   logic                    np_wr_ok;

   logic                    next_page_r;
   logic                    ack_r;
   logic                    msg_page_r;
   logic                    ack2_r;
   logic                    toggle_r;
   logic [`NP_CODE_W-1:0]   code_r;
   logic [NE-1:0]           mask_r;
   logic                    legacy_r;
   logic                    irq_n_r;
   np_irq_pkg::np_word_t    np_word_r;
   np_irq_pkg::np_word_t    np_word_nxt;

   logic                    link_prev_r;
   logic                    lock_prev_r;
   logic                    primed_r;
   logic [NE-1:0]           ev_set;
   logic [NE-1:0]           ev_clr;
   logic [NE-1:0]           eff_mask;
   logic [NE-1:0]           status;
   logic                    pending;

   // Bus handshake: take at an edge with waitrequest high, answer low for one cycle
   assign req    = read_in | write_in;
   assign launch = req & waitrequest_r;
   assign done   = req & ~waitrequest_r;
   assign idx    = address_in[`AV_ADDR_W-1:2];
   assign wr_lo  = done & write_in & byteenable_in[0];
   assign wr_hi  = done & write_in & byteenable_in[1];

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         waitrequest_r <= 1'b1;
      end else begin
         waitrequest_r <= ~launch;
      end
   end

   // Read mux; unmapped words read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (idx)
         `REG_IDX_NP_TX: begin
            rd_word[15:0] = {next_page_r, ack_r, msg_page_r, ack2_r, toggle_r, code_r};
         end
         `REG_IDX_MASK: begin
            rd_word[`IRQ_FIELD_LSB +: NE] = mask_r;
         end
         `REG_IDX_STATUS: begin
            rd_word[`IRQ_FIELD_LSB +: NE] = status;
         end
         `REG_IDX_CONFIG: begin
            rd_word[`CFG_BIT_LEGACY] = legacy_r;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         readdata_r <= 32'h0000_0000;
      end else if (launch & read_in) begin
         readdata_r <= rd_word;
      end
   end

   // Legacy compatibility mode
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         legacy_r <= 1'b0;
      end else if (wr_lo && idx == `REG_IDX_CONFIG) begin
         legacy_r <= writedata_in[`CFG_BIT_LEGACY];
      end
   end

   assign np_wr_ok = (idx == `REG_IDX_NP_TX) & ~legacy_r;

   // Writable next-page fields
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         next_page_r <= 1'b0;
         msg_page_r  <= `NP_MSG_PAGE_RESET;
         ack2_r      <= 1'b0;
      end else if (wr_hi & np_wr_ok) begin
         next_page_r <= writedata_in[`NP_BIT_NEXT_PAGE];
         msg_page_r  <= writedata_in[`NP_BIT_MSG_PAGE];
         ack2_r      <= writedata_in[`NP_BIT_ACK2];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         code_r <= `NP_CODE_RESET;
      end else begin
         if (wr_lo & np_wr_ok) begin
            code_r[7:0] <= writedata_in[7:0];
         end
         if (wr_hi & np_wr_ok) begin
            code_r[10:8] <= writedata_in[10:8];
         end
      end
   end

   // Acknowledge: set by consistent partner data, cleared when our page goes out
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= lp_consistent_in | (ack_r & ~page_sent_in);
      end
   end

   // Toggle flips on each next page sent
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         toggle_r <= 1'b0;
      end else if (page_sent_in) begin
         toggle_r <= ~toggle_r;
      end
   end

   // Word handed to negotiation; legacy mode forces writable fields to their defaults
   always_comb begin
      np_word_nxt           = '0;
      np_word_nxt.ack       = ack_r;
      np_word_nxt.toggle    = toggle_r;
      np_word_nxt.next_page = legacy_r ? 1'b0 : next_page_r;
      np_word_nxt.msg_page  = legacy_r ? `NP_MSG_PAGE_RESET : msg_page_r;
      np_word_nxt.ack2      = legacy_r ? 1'b0 : ack2_r;
      np_word_nxt.code      = legacy_r ? `NP_CODE_RESET : code_r;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         np_word_r <= '0;
      end else begin
         np_word_r <= np_word_nxt;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         mask_r <= `IRQ_MASK_RESET;
      end else if (wr_hi && idx == `REG_IDX_MASK && !legacy_r) begin
         mask_r <= writedata_in[`IRQ_FIELD_LSB +: NE];
      end
   end

   assign eff_mask = legacy_r ? '0 : mask_r;

   // Change detection for level events; primed after the first sample
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         link_prev_r <= 1'b0;
         lock_prev_r <= 1'b0;
         primed_r    <= 1'b0;
      end else begin
         link_prev_r <= events_in.link_up;
         lock_prev_r <= events_in.lock_ok;
         primed_r    <= 1'b1;
      end
   end

   assign ev_set[3] = events_in.cim_unstable;
   assign ev_set[2] = primed_r & (events_in.link_up ^ link_prev_r);
   assign ev_set[1] = primed_r & (events_in.lock_ok ^ lock_prev_r);
   assign ev_set[0] = events_in.premature_end;

   // Clear only what the completed read returned
   assign ev_clr = (done && read_in && idx == `REG_IDX_STATUS)
                   ? readdata_r[`IRQ_FIELD_LSB +: NE] : '0;

   irq_status_bank #(
      .N (NE)
   ) u_status (
      .clk_in      (clk_in),
      .srst_in     (srst_in),
      .set_in      (ev_set),
      .clr_in      (ev_clr),
      .mask_in     (eff_mask),
      .status_out  (status),
      .pending_out (pending)
   );

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= ~pending;
      end
   end

   assign readdata_out    = readdata_r;
   assign waitrequest_out = waitrequest_r;
   assign np_tx_word_out  = np_word_r;
   assign legacy_mode_out = legacy_r;
   assign irq_n_out       = irq_n_r;

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence s_take;
      req & waitrequest_out;
   endsequence

   sequence s_answer;
      req & !waitrequest_out;
   endsequence

   a_bus_answer_once: assert property (s_take |=> !waitrequest_out ##1 waitrequest_out)
      else $error("waitrequest not low for exactly one cycle");

   a_legacy_mask_hold: assert property (legacy_r |=> $stable(mask_r))
      else $error("mask changed in legacy mode");

   a_legacy_np_hold: assert property (legacy_r |=> $stable(code_r) && $stable(ack2_r))
      else $error("next-page field changed in legacy mode");

   a_mask_drives_irq: assert property ((status & eff_mask) != '0 |=> !irq_n_out)
      else $error("enabled event did not assert interrupt");

   a_unmasked_quiet: assert property ((status & eff_mask) == '0 |=> irq_n_out)
      else $error("interrupt asserted with no enabled event");

   a_event_recorded: assert property (ev_set[3] |=> status[3])
      else $error("event not recorded in status");

   a_link_change_rec: assert property (
      primed_r && $changed(events_in.link_up) |=> status[2])
      else $error("link change not recorded");

   a_status_read_clr: assert property (
      s_take ##1 (s_answer and (read_in && idx == `REG_IDX_STATUS
                                && readdata_r[15] && !ev_set[3]))
      |=> !status[3])
      else $error("status bit not cleared by read");

   a_ack_on_consistent: assert property (lp_consistent_in |=> ##1 np_tx_word_out.ack)
      else $error("acknowledge not set");

   a_toggle_flips: assert property (page_sent_in |=> toggle_r != $past(toggle_r))
      else $error("toggle did not alternate");

   a_np_write_takes: assert property (
      wr_hi && np_wr_ok |=> next_page_r == $past(writedata_in[`NP_BIT_NEXT_PAGE]))
      else $error("next-page bit not written");

   a_msg_page_write: assert property (
      wr_hi && np_wr_ok |=> msg_page_r == $past(writedata_in[`NP_BIT_MSG_PAGE]))
      else $error("message-page bit not written");

   a_ack2_write: assert property (
      wr_hi && np_wr_ok |=> ack2_r == $past(writedata_in[`NP_BIT_ACK2]))
      else $error("acknowledge-2 bit not written");

   a_code_low_write: assert property (
      wr_lo && np_wr_ok |=> code_r[7:0] == $past(writedata_in[7:0]))
      else $error("code field low byte not written");

   a_code_reset_val: assert property (
      $fell(srst_in) |-> code_r == `NP_CODE_RESET)
      else $error("code field not at null message after reset");

   a_ack_clear_sent: assert property (
      page_sent_in && !lp_consistent_in |=> !ack_r)
      else $error("acknowledge not cleared when page sent");

   a_toggle_hold: assert property (
      !page_sent_in |=> $stable(toggle_r))
      else $error("toggle changed with no page sent");

   a_lock_change_rec: assert property (
      primed_r && $changed(events_in.lock_ok) |=> status[1])
      else $error("descrambler lock change not recorded");

   a_premature_rec: assert property (
      events_in.premature_end |=> status[0])
      else $error("premature end not recorded");

   a_cim_irq: assert property (
      status[3] && mask_r[3] && !legacy_r |=> !irq_n_out)
      else $error("carrier integrity event did not assert interrupt");

   a_link_irq: assert property (
      status[2] && mask_r[2] && !legacy_r |=> !irq_n_out)
      else $error("link change did not assert interrupt");

   a_status_sticky: assert property (
      status[2] && !ev_clr[2] |=> status[2])
      else $error("status bit lost without a read");

   a_legacy_quiet: assert property (
      legacy_r |=> irq_n_out)
      else $error("interrupt asserted in legacy mode");

   a_legacy_word_def: assert property (
      legacy_r |=> !np_tx_word_out.next_page && np_tx_word_out.msg_page && !np_tx_word_out.ack2)
      else $error("next-page word not at defaults in legacy mode");

   sequence s_mask_write;
      s_answer ##0 (write_in && byteenable_in[1] && idx == `REG_IDX_MASK && !legacy_r);
   endsequence

   a_mask_write_takes: assert property (
      s_mask_write |=> mask_r == $past(writedata_in[`IRQ_FIELD_LSB +: NE]))
      else $error("mask write not taken");

   a_read_data_load: assert property (
      s_take ##0 read_in |=> readdata_out == $past(rd_word))
      else $error("read data not loaded at take");

   a_wait_idle: assert property (
      !req |=> waitrequest_out)
      else $error("waitrequest low with no request");

endmodule : np_irq_regs

// ### dv/mgmt_master.sv
// Station management master model driving the Avalon-MM register port
// Assumes a slave on clk_in that answers by dropping waitrequest
`timescale 1ns/1ps
module mgmt_master (
   input  wire logic        clk_in,
   output logic [7:0]       address_out,
   output logic             read_out,
   output logic             write_out,
   output logic [31:0]      writedata_out,
   output logic [3:0]       byteenable_out,
   input  wire logic [31:0] readdata_in,
   input  wire logic        waitrequest_in
);
   initial begin
      address_out = 8'hFF;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'hFFFFFFFF;
      byteenable_out = 4'h3;
   end

   // One access; caller enters just after a rising edge
   task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                         output logic [15:0] q);
      address_out <= a;
      writedata_out <= {16'h0000, d};
      write_out <= wr;
      read_out <= !wr;
      do @(posedge clk_in); while (waitrequest_in !== 1'b0);
      q = readdata_in[15:0];
      read_out <= 1'b0;
      write_out <= 1'b0;
      address_out <= ~a;
      writedata_out <= ~{16'h0000, d};
      @(posedge clk_in);
   endtask : access
endmodule : mgmt_master

// ### dv/test_np_irq_regs.sv
// Self-checking bench for the next-page word and interrupt mask registers
// Assumes np_irq_regs on one 40 MHz clock with synchronous active-high reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_np_irq_regs;
   logic                 clk = 1'b0;
   logic                 srst = 1'b1;
   logic [7:0]           addr;
   logic                 rd_s, wr_s;
   logic [31:0]          wdata, rdata;
   logic [3:0]           be;
   logic                 wait_s;
   logic [3:0]           ev = 4'h0;
   logic                 lp = 1'b0;
   logic                 ps = 1'b0;
   np_irq_pkg::np_word_t np_out;
   logic                 legacy_out, irq_n;
   int                   n_fail = 0;
   int                   tests_run = 0;
   int                   cyc = 0;
   logic [31:0]          seed = 32'hF3A6;
   logic [15:0]          np_st = 16'h2001;
   logic                 ack_m = 1'b0;
   logic                 tog_m = 1'b0;
   logic [3:0]           mask_m = 4'h4;
   logic [3:0]           st_m = 4'h0;
   logic                 legacy_m = 1'b0;

   initial begin
      forever #12.5 clk = ~clk;
   end

   mgmt_master m (.clk_in(clk), .address_out(addr), .read_out(rd_s), .write_out(wr_s),
      .writedata_out(wdata), .byteenable_out(be), .readdata_in(rdata),
      .waitrequest_in(wait_s));

   np_irq_regs dut (.clk_in(clk), .srst_in(srst), .address_in(addr), .read_in(rd_s),
      .write_in(wr_s), .writedata_in(wdata), .byteenable_in(be), .readdata_out(rdata),
      .waitrequest_out(wait_s), .events_in(np_irq_pkg::irq_event_t'(ev)),
      .lp_consistent_in(lp), .page_sent_in(ps), .np_tx_word_out(np_out),
      .legacy_mode_out(legacy_out), .irq_n_out(irq_n));

   task automatic print_verdict;
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         print_verdict();
      end
   end

   // Expected next-page word; leg selects the defaults shown in legacy mode
   function automatic logic [15:0] np_exp(input logic leg);
      np_exp = leg ? {1'b0, ack_m, 2'b10, tog_m, 11'h001}
                   : {np_st[15], ack_m, np_st[13:12], tog_m, np_st[10:0]};
   endfunction : np_exp

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      m.access(1'b1, a, d, q);
      if (a == 8'h1C && !legacy_m) np_st = d & 16'hB7FF;
      if (a == 8'h40 && !legacy_m) mask_m = d[15:12];
      if (a == 8'h70) legacy_m = d[0];
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      m.access(1'b0, a, 16'h0000, q);
      `CHK("readdata", e, q)
   endtask : rdchk

   // Raise event i, check pin and status, then read-clear and check release
   task automatic fire(input int i);
      ev <= ev ^ (4'h1 << i);
      @(posedge clk);
      if (i == 0 || i == 3) ev[i] <= 1'b0;
      repeat (3) @(posedge clk);
      st_m[i] = 1'b1;
      `CHK("irq_n", !(mask_m[i] && !legacy_m), irq_n)
      rdchk(8'h44, {st_m, 12'h000});
      st_m = 4'h0;
      repeat (3) @(posedge clk);
      `CHK("irq_n_clr", 1'b1, irq_n)
   endtask : fire

   initial begin
      logic [31:0] d;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rdchk(8'h1C, 16'h2001);
      rdchk(8'h40, 16'h4000);
      rdchk(8'h08, 16'h0000);
      `CHK("np_out", np_exp(1'b0), np_out)
      for (int i = 0; i < 4; i++) begin
         wr(8'h40, 16'h1000 << i);
         fire(i);
         wr(8'h40, 16'h0000);
         fire(i);
      end
      rdchk(8'h44, 16'h0000);
      repeat (4) begin
         d = $random(seed);
         wr(8'h1C, d[15:0]);
         rdchk(8'h1C, np_exp(1'b0));
         `CHK("np_out", np_exp(1'b0), np_out)
      end
      repeat (2) begin
         lp <= 1'b1;
         @(posedge clk);
         lp <= 1'b0;
         repeat (3) @(posedge clk);
         ack_m = 1'b1;
         rdchk(8'h1C, np_exp(1'b0));
         ps <= 1'b1;
         @(posedge clk);
         ps <= 1'b0;
         repeat (3) @(posedge clk);
         ack_m = 1'b0;
         tog_m = !tog_m;
         rdchk(8'h1C, np_exp(1'b0));
      end
      wr(8'h40, 16'h4000);
      wr(8'h70, 16'h0001);
      wr(8'h1C, 16'hFFFF);
      wr(8'h40, 16'hF000);
      rdchk(8'h40, 16'h4000);
      rdchk(8'h1C, np_exp(1'b0));
      `CHK("np_out", np_exp(1'b1), np_out)
      `CHK("legacy", 1'b1, legacy_out)
      fire(1);
      wr(8'h70, 16'h0000);
      fire(1);
      fire(2);
      print_verdict();
   end
endmodule : test_np_irq_regs
